/* File: logic/clk_ctrl_pkg.sv */
// Constants and types for the clock generation block
package clk_ctrl_pkg;
  // Register map (word index on the plain register port)
  localparam logic [3:0] CSR_ADDR       = 4'h0;
  localparam logic [3:0] TRIM_ADDR      = 4'h1;
  localparam logic [3:0] PRESCALE_ADDR  = 4'h2;
  localparam logic [3:0] STATUS_ADDR    = 4'h3;
  // Control/status fields
  localparam int LOCK_BIT   = 0;
  localparam int ENABLE_BIT = 1;
  localparam int FACTOR_BIT = 2;
  // Status register fields
  localparam int STAT_REF_ON     = 0;
  localparam int STAT_LOOP_ON    = 1;
  localparam int STAT_SATURATED  = 2;
  localparam int STAT_STARTED    = 3;
  // Reset values and prescaler limit
  localparam logic [7:0] TRIM_FACTORY_DEFAULT = 8'h80;
  localparam logic [3:0] PRESCALE_DIV1        = 4'h0;
  localparam logic [3:0] PRESCALE_DIV8        = 4'h3;
  localparam logic [3:0] PRESCALE_MAX         = 4'h8;
  // Trim code at which the divided reference reaches 1 MHz
  localparam logic [7:0] TRIM_REF_LIMIT       = 8'hc0;
  // Clock source select codes
  localparam logic [3:0] SRC_EXT_CLOCK = 4'h0;
  localparam logic [3:0] SRC_LOOP_EXT  = 4'h1;
  localparam logic [3:0] SRC_RC        = 4'h2;
  localparam logic [3:0] SRC_LOOP_RC   = 4'h3;
  // Frequency figures
  localparam int REF_KHZ         = 1000;
  localparam int LOOP_MULT       = 64;
  localparam int FAST_HI_MHZ     = 64;
  localparam int FAST_LO_MHZ     = 32;
  localparam int FAST_SAT_MHZ    = 70;
  localparam int WDT_OSC_KHZ     = 128;
  localparam int EXT_MAX_MHZ     = 16;
  // Timing
  localparam int CLK_MHZ         = 20;
  localparam int LOCK_MS         = 100;
  localparam int LOCK_CYCLES     = LOCK_MS * 1000 * CLK_MHZ;
  localparam int RESET_BASE_CK   = 14;
  localparam int LOOP_SLEEP_SHORT_CK = 1024;
  localparam int LOOP_SLEEP_LONG_CK  = 16384;
  localparam int EXT_SLEEP_CK    = 6;
  localparam int LOOP_EXTRA_A_US = 4000;
  localparam int LOOP_EXTRA_B_US = 64000;
  localparam int EXT_EXTRA_A_US  = 4100;
  localparam int EXT_EXTRA_B_US  = 65000;
  localparam int LOOP_EXTRA_A_CK = LOOP_EXTRA_A_US * CLK_MHZ;
  localparam int LOOP_EXTRA_B_CK = LOOP_EXTRA_B_US * CLK_MHZ;
  localparam int EXT_EXTRA_A_CK  = EXT_EXTRA_A_US * CLK_MHZ;
  localparam int EXT_EXTRA_B_CK  = EXT_EXTRA_B_US * CLK_MHZ;
  localparam int WDT_DIV         = (CLK_MHZ * 1000) / (WDT_OSC_KHZ * 2);

  typedef enum logic [1:0] {
    ST_HOLD  = 2'b00,
    ST_WAIT  = 2'b01,
    ST_RUN   = 2'b10,
    ST_SLEEP = 2'b11
  } start_state_t;
endpackage

/* File: logic/prescale_if.sv */
// Prescaler setting and divided clock between top and divider
`timescale 1ns/10ps
interface prescale_if;
  logic [3:0] division_select;
  logic       divided_clock;
  modport ctrl (output division_select, input divided_clock);
  modport div  (input division_select, output divided_clock);
endinterface

/* File: logic/sys_prescaler.sv */
// System clock prescaler producing the divided clock level
`timescale 1ns/10ps
module sys_prescaler
  import clk_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic clock_in,
  input  wire logic rst_b_in,
  // Setting and output
  prescale_if.div   pre
);
  logic [8:0] count_reg;
  logic [8:0] count_next;
  logic       out_reg;
  logic       out_next;
  logic [8:0] half;

  always_comb begin
    half = 9'h001;
    if (pre.division_select <= PRESCALE_MAX) begin
      half = 9'(9'h001 << pre.division_select);
    end
    count_next = 9'(count_reg + 9'h001);
    out_next   = out_reg;
    if (pre.division_select == PRESCALE_DIV1) begin
      out_next   = ~out_reg;
      count_next = 9'h000;
    end else if (count_next >= (half >> 1)) begin
      out_next   = ~out_reg;
      count_next = 9'h000;
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      count_reg <= 9'h000;
      out_reg   <= 1'b0;
    end else begin
      count_reg <= count_next;
      out_reg   <= out_next;
    end
  end

  assign pre.divided_clock = out_reg;
endmodule

/* File: logic/clock_control.sv */
// Fast multiplying loop control, start-up delays, watchdog oscillator and clock output
//
// Overview of operation
// - Fast clock is 64x a 1 MHz reference
// - Enable bit runs loop and starts RC
// - Enable reads one when loop is system clock
// - Lock flag gates fast clock to stages
// - Lock flag sets about 100 ms later
// - Factor bit selects 64 or 32 MHz
// - Bits 7 to 3 read zero
// - Trim moves fast clock proportionally
// - Reference above 1 MHz saturates, unlocked
// - Power-down and standby stop RC and loop
// - Loop-from-RC start-up delay table
// - 128 kHz oscillator clocks the watchdog
// - Code 0000 selects external clock input
// - External clock start-up delay table
// - Clock output overrides pin, even in reset
// - Clock output carries the prescaled clock
// - Trim loads factory value on reset
// - Prescaler default follows divide-by-eight option
`timescale 1ns/10ps
module clock_control
  import clk_ctrl_pkg::*;
#(
  parameter int LOCK_DELAY_CYCLES = LOCK_CYCLES,
  parameter int LOOP_DELAY_A      = LOOP_EXTRA_A_CK,
  parameter int LOOP_DELAY_B      = LOOP_EXTRA_B_CK,
  parameter int EXT_DELAY_A       = EXT_EXTRA_A_CK,
  parameter int EXT_DELAY_B       = EXT_EXTRA_B_CK,
  parameter int SLEEP_LONG        = LOOP_SLEEP_LONG_CK
) (
  // Clock and reset
  input  wire logic       clock_in,
  input  wire logic       rst_b_in,
  // Register port
  input  wire logic [3:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_write_in,
  input  wire logic       reg_read_in,
  output logic      [7:0] reg_rdata_out,
  // Option straps, static while running
  input  wire logic [3:0] clock_source_select_in,
  input  wire logic [1:0] startup_time_select_in,
  input  wire logic       clock_output_option_in,
  input  wire logic       divide_by_eight_option_in,
  input  wire logic [7:0] factory_trim_in,
  // Sleep control from the power manager
  input  wire logic       power_down_sleep_in,
  input  wire logic       standby_sleep_in,
  // Clock status towards the rest of the chip
  output logic            ref_osc_on_out,
  output logic            multiplier_run_out,
  output logic            fast_clock_enable_out,
  output logic            fast_clock_64mhz_out,
  output logic            loop_saturated_out,
  output logic      [7:0] rc_trim_value_out,
  output logic            core_ready_out,
  output logic            wdt_clock_out,
  // Clock output pin
  output logic            clock_output_pin_out,
  output logic            clock_output_pin_oe_out,
  // Port function of the pin when not overridden
  input  wire logic       port_pin_value_in,
  input  wire logic       port_pin_oe_in
);
  // Sleep inputs from outside cross two flip-flops
  logic [1:0] pd_sync_reg;
  logic [1:0] sb_sync_reg;
  logic       sleeping;

  // Register state
  logic       enable_reg;
  logic       enable_next;
  logic       factor_reg;
  logic       factor_next;
  logic       lock_reg;
  logic       lock_next;
  logic [7:0] trim_reg;
  logic [7:0] trim_next;
  logic [3:0] prescale_reg;
  logic [3:0] prescale_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic       init_reg;
  logic       init_next;
  logic [31:0] lock_cnt_reg;
  logic [31:0] lock_cnt_next;

  // Start-up sequencer
  start_state_t state_reg;
  start_state_t state_next;
  logic [31:0]  start_cnt_reg;
  logic [31:0]  start_cnt_next;
  logic [31:0]  reset_delay;
  logic [31:0]  sleep_delay;
  logic         ready_reg;
  logic         ready_next;

  // Watchdog oscillator divider
  logic [7:0] wdt_cnt_reg;
  logic [7:0] wdt_cnt_next;
  logic       wdt_reg;
  logic       wdt_next;

  // Output flops
  logic       ref_on_reg;
  logic       ref_on_next;
  logic       run_reg;
  logic       run_next;
  logic       fast_en_reg;
  logic       fast_en_next;
  logic       sat_reg;
  logic       sat_next;
  logic       pin_reg;
  logic       pin_next;
  logic       pin_oe_reg;
  logic       pin_oe_next;

  logic       loop_is_system;
  logic       enable_eff;
  logic [7:0] csr_view;

  prescale_if pre ();

  sys_prescaler u_prescaler (
    .clock_in (clock_in),
    .rst_b_in (rst_b_in),
    .pre      (pre)
  );

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pd_sync_reg <= 2'b00;
      sb_sync_reg <= 2'b00;
    end else begin
      pd_sync_reg <= {pd_sync_reg[0], power_down_sleep_in};
      sb_sync_reg <= {sb_sync_reg[0], standby_sleep_in};
    end
  end

  assign sleeping = pd_sync_reg[1] | sb_sync_reg[1];
  assign loop_is_system = (clock_source_select_in == SRC_LOOP_RC) ||
                          (clock_source_select_in == SRC_LOOP_EXT);
  assign enable_eff = enable_reg | loop_is_system;
  assign csr_view = {5'h00, factor_reg, enable_eff, lock_reg};

  // Delay tables per clock source and start-up code
  always_comb begin
    reset_delay = 32'(RESET_BASE_CK);
    sleep_delay = 32'(LOOP_SLEEP_SHORT_CK);
    if (clock_source_select_in == SRC_LOOP_RC) begin
      unique case (startup_time_select_in)
        2'b00: reset_delay = 32'(RESET_BASE_CK);
        2'b01: reset_delay = 32'(RESET_BASE_CK + LOOP_DELAY_A);
        2'b10: reset_delay = 32'(RESET_BASE_CK + LOOP_DELAY_B);
        2'b11: begin
          reset_delay = 32'(RESET_BASE_CK);
          sleep_delay = 32'(SLEEP_LONG);
        end
      endcase
    end else begin
      sleep_delay = 32'(EXT_SLEEP_CK);
      unique case (startup_time_select_in)
        2'b00: reset_delay = 32'(RESET_BASE_CK);
        2'b01: reset_delay = 32'(RESET_BASE_CK + EXT_DELAY_A);
        2'b10: reset_delay = 32'(RESET_BASE_CK + EXT_DELAY_B);
        2'b11: reset_delay = 32'(RESET_BASE_CK);
      endcase
    end
  end

  // Start-up sequencer: reset delay, run, sleep, wake delay
  always_comb begin
    state_next     = state_reg;
    start_cnt_next = start_cnt_reg;
    unique case (state_reg)
      ST_HOLD: begin
        state_next     = ST_WAIT;
        start_cnt_next = reset_delay;
      end
      ST_WAIT: begin
        if (start_cnt_reg <= 32'h00000001) begin
          state_next = ST_RUN;
        end
        start_cnt_next = (start_cnt_reg == 32'h00000000) ? 32'h00000000 : 32'(start_cnt_reg - 32'h00000001);
      end
      ST_RUN: begin
        if (sleeping) begin
          state_next = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (!sleeping) begin
          state_next     = ST_WAIT;
          start_cnt_next = sleep_delay;
        end
      end
    endcase
    ready_next = (state_next == ST_RUN);
  end

  // Register writes, reads, trim and prescaler handling
  always_comb begin
    init_next     = 1'b1;
    enable_next   = enable_reg;
    factor_next   = factor_reg;
    trim_next     = trim_reg;
    prescale_next = prescale_reg;
    rdata_next    = 8'h00;
    if (!init_reg) begin
      trim_next = factory_trim_in;
      prescale_next = divide_by_eight_option_in ? PRESCALE_DIV8 : PRESCALE_DIV1;
      enable_next = loop_is_system;
    end else if (reg_write_in) begin
      unique case (reg_addr_in)
        CSR_ADDR: begin
          factor_next = reg_wdata_in[FACTOR_BIT];
          enable_next = reg_wdata_in[ENABLE_BIT];
        end
        TRIM_ADDR:     trim_next = reg_wdata_in;
        PRESCALE_ADDR: begin
          if (reg_wdata_in[3:0] <= PRESCALE_MAX) begin
            prescale_next = reg_wdata_in[3:0];
          end
        end
        default: ;
      endcase
    end
    if (reg_read_in) begin
      unique case (reg_addr_in)
        CSR_ADDR:      rdata_next = csr_view;
        TRIM_ADDR:     rdata_next = trim_reg;
        PRESCALE_ADDR: rdata_next = {4'h0, prescale_reg};
        STATUS_ADDR:   rdata_next = {4'h0, (state_reg == ST_RUN), sat_reg, run_reg, ref_on_reg};
        default:       rdata_next = 8'h00;
      endcase
    end
  end

  always_comb begin
    run_next    = enable_eff & ~sleeping;
    ref_on_next = run_next | (clock_source_select_in == SRC_RC) | loop_is_system;
    if (sleeping) begin
      ref_on_next = 1'b0;
    end
    sat_next    = run_next & (trim_reg > TRIM_REF_LIMIT);
    lock_next   = lock_reg;
    lock_cnt_next = lock_cnt_reg;
    if (!run_next) begin
      lock_next     = 1'b0;
      lock_cnt_next = 32'h00000000;
    end else if (sat_next) begin
      lock_next     = 1'b0;
    end else if (lock_cnt_reg >= 32'(LOCK_DELAY_CYCLES - 1)) begin
      lock_next = 1'b1;
    end else begin
      lock_cnt_next = 32'(lock_cnt_reg + 32'h00000001);
    end
    fast_en_next = lock_reg & run_reg;
    pin_oe_next = clock_output_option_in ? 1'b1 : port_pin_oe_in;
    pin_next    = clock_output_option_in ? pre.divided_clock : port_pin_value_in;
    wdt_cnt_next = 8'(wdt_cnt_reg + 8'h01);
    wdt_next     = wdt_reg;
    if (wdt_cnt_reg >= 8'(WDT_DIV - 1)) begin
      wdt_cnt_next = 8'h00;
      wdt_next     = ~wdt_reg;
    end
  end

  assign pre.division_select = prescale_reg;

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      init_reg      <= 1'b0;
      enable_reg    <= 1'b0;
      factor_reg    <= 1'b0;
      lock_reg      <= 1'b0;
      lock_cnt_reg  <= 32'h00000000;
      trim_reg      <= TRIM_FACTORY_DEFAULT;
      prescale_reg  <= PRESCALE_DIV1;
      rdata_reg     <= 8'h00;
      state_reg     <= ST_HOLD;
      ready_reg     <= 1'b0;
      start_cnt_reg <= 32'h00000000;
      wdt_cnt_reg   <= 8'h00;
      wdt_reg       <= 1'b0;
      ref_on_reg    <= 1'b0;
      run_reg       <= 1'b0;
      fast_en_reg   <= 1'b0;
      sat_reg       <= 1'b0;
    end else begin
      init_reg      <= init_next;
      enable_reg    <= enable_next;
      factor_reg    <= factor_next;
      lock_reg      <= lock_next;
      lock_cnt_reg  <= lock_cnt_next;
      trim_reg      <= trim_next;
      prescale_reg  <= prescale_next;
      rdata_reg     <= rdata_next;
      state_reg     <= state_next;
      ready_reg     <= ready_next;
      start_cnt_reg <= start_cnt_next;
      wdt_cnt_reg   <= wdt_cnt_next;
      wdt_reg       <= wdt_next;
      ref_on_reg    <= ref_on_next;
      run_reg       <= run_next;
      fast_en_reg   <= fast_en_next;
      sat_reg       <= sat_next;
    end
  end

  always_ff @(posedge clock_in) begin
    pin_reg    <= pin_next;
    pin_oe_reg <= pin_oe_next;
  end

  // 64x reference, factor select, trim passed through
  assign reg_rdata_out          = rdata_reg;
  assign ref_osc_on_out         = ref_on_reg;
  assign multiplier_run_out     = run_reg;
  assign fast_clock_enable_out  = fast_en_reg;
  assign fast_clock_64mhz_out   = factor_reg;
  assign loop_saturated_out     = sat_reg;
  assign rc_trim_value_out      = trim_reg;
  assign core_ready_out         = ready_reg;
  assign wdt_clock_out          = wdt_reg;
  assign clock_output_pin_out   = pin_reg;
  assign clock_output_pin_oe_out = pin_oe_reg;
endmodule

/* File: verif/clock_control_assertions.sv */
// Concurrent checks on the ports of the clock generation block
`timescale 1ns/10ps
module clock_control_checker
  import clk_ctrl_pkg::*;
#(
  parameter int LOCK_DELAY_CYCLES = LOCK_CYCLES
) (
  // Clock and reset
  input wire logic       clock_in,
  input wire logic       rst_b_in,
  // Register port
  input wire logic [3:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic       reg_write_in,
  input wire logic       reg_read_in,
  input wire logic [7:0] reg_rdata_out,
  // Straps and sleep
  input wire logic       clock_output_option_in,
  input wire logic       power_down_sleep_in,
  input wire logic       standby_sleep_in,
  // Clock status
  input wire logic       ref_osc_on_out,
  input wire logic       multiplier_run_out,
  input wire logic       fast_clock_enable_out,
  input wire logic       fast_clock_64mhz_out,
  input wire logic       loop_saturated_out,
  input wire logic [7:0] rc_trim_value_out,
  input wire logic       wdt_clock_out,
  // Clock output pin
  input wire logic       clock_output_pin_out,
  input wire logic       clock_output_pin_oe_out,
  input wire logic       port_pin_value_in,
  input wire logic       port_pin_oe_in
);
  localparam int MIN_RUN = LOCK_DELAY_CYCLES - 1;
  logic [15:0] run_cnt_reg, run_cnt_next;
  logic [1:0]  since_rst_reg, since_rst_next;
  logic [7:0]  wdt_cnt_reg, wdt_cnt_next;
  logic        wdt_prev_reg, wdt_seen_reg, wdt_seen_next;

  always_comb begin
    run_cnt_next = multiplier_run_out ? run_cnt_reg + 16'h1 : 16'h0;
    since_rst_next = (since_rst_reg == 2'h3) ? 2'h3 : since_rst_reg + 2'h1;
    wdt_cnt_next = (wdt_clock_out != wdt_prev_reg) ? 8'h1 : wdt_cnt_reg + 8'h1;
    wdt_seen_next = wdt_seen_reg | (wdt_clock_out != wdt_prev_reg);
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      run_cnt_reg <= 16'h0;
      since_rst_reg <= 2'h0;
      wdt_cnt_reg <= 8'h0;
      wdt_prev_reg <= 1'b0;
      wdt_seen_reg <= 1'b0;
    end else begin
      run_cnt_reg <= run_cnt_next;
      since_rst_reg <= since_rst_next;
      wdt_cnt_reg <= wdt_cnt_next;
      wdt_prev_reg <= wdt_clock_out;
      wdt_seen_reg <= wdt_seen_next;
    end
  end

  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);

  a_reserved_zero: assert property (
    $past(reg_read_in && reg_addr_in == CSR_ADDR) |-> reg_rdata_out[7:3] == 5'h00)
    else $error("reserved control bits read nonzero");
  a_run_needs_ref: assert property (multiplier_run_out |-> ref_osc_on_out)
    else $error("loop running without reference");
  a_fast_needs_run: assert property (fast_clock_enable_out |-> $past(multiplier_run_out))
    else $error("fast clock handed over while loop stopped");
  a_lock_wait_min: assert property (
    $rose(fast_clock_enable_out) |-> run_cnt_reg >= MIN_RUN)
    else $error("fast clock enabled before lock interval");
  a_sleep_stops_loop: assert property (
    (power_down_sleep_in || standby_sleep_in) [*5] |->
      !multiplier_run_out && !ref_osc_on_out && !fast_clock_enable_out)
    else $error("loop or reference running in sleep");
  a_sat_unlocked: assert property (loop_saturated_out [*2] |-> !fast_clock_enable_out)
    else $error("fast clock enabled while saturated");
  a_trim_follows: assert property (
    reg_write_in && reg_addr_in == TRIM_ADDR |-> ##2 rc_trim_value_out == $past(reg_wdata_in, 2))
    else $error("trim output does not follow write");
  a_factor_follows: assert property (
    reg_write_in && reg_addr_in == CSR_ADDR |-> ##2 fast_clock_64mhz_out == $past(reg_wdata_in[2], 2))
    else $error("factor output does not follow write");
  a_pin_override: assert property (
    clock_output_option_in && since_rst_reg == 2'h3 |-> clock_output_pin_oe_out)
    else $error("clock pin not driven with option on");
  a_pin_passthru: assert property (
    !clock_output_option_in && since_rst_reg == 2'h3 |->
      clock_output_pin_out == $past(port_pin_value_in) && clock_output_pin_oe_out == $past(port_pin_oe_in))
    else $error("pin port function not passed through");
  a_wdt_half_period: assert property (
    wdt_seen_reg && wdt_clock_out != wdt_prev_reg |-> wdt_cnt_reg == 8'(WDT_DIV))
    else $error("watchdog clock half period wrong");
endmodule

bind clock_control clock_control_checker #(.LOCK_DELAY_CYCLES(LOCK_DELAY_CYCLES)) chk_u (
  .clock_in, .rst_b_in, .reg_addr_in, .reg_wdata_in, .reg_write_in, .reg_read_in, .reg_rdata_out,
  .clock_output_option_in, .power_down_sleep_in, .standby_sleep_in, .ref_osc_on_out, .multiplier_run_out,
  .fast_clock_enable_out, .fast_clock_64mhz_out, .loop_saturated_out, .rc_trim_value_out, .wdt_clock_out,
  .clock_output_pin_out, .clock_output_pin_oe_out, .port_pin_value_in, .port_pin_oe_in);

/* File: verif/pwm_stage_model.sv */
// Model of the PWM stage controllers that consume the fast clock
`timescale 1ns/10ps
module pwm_stage_model
  import clk_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic        clock_in,
  input  wire logic        rst_b_in,
  // Fast clock hand-over
  input  wire logic        fast_enable_in,
  input  wire logic        fast_64mhz_in,
  // Fast ticks taken, in MHz per system cycle
  output logic      [15:0] fast_ticks_out
);
  logic [15:0] ticks_next;

  always_comb begin
    ticks_next = fast_ticks_out;
    // counts only a locked clock at its rate
    if (fast_enable_in) begin
      ticks_next = fast_ticks_out + (fast_64mhz_in ? 16'(FAST_HI_MHZ) : 16'(FAST_LO_MHZ));
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      fast_ticks_out <= 16'h0;
    end else begin
      fast_ticks_out <= ticks_next;
    end
  end
endmodule

/* File: verif/clock_control_tb.sv */
// Self-checking bench for the clock generation block
`timescale 1ns/10ps
module clock_control_tb;
  import clk_ctrl_pkg::*;
  localparam int LOCK_N = 20;
  logic        clock_in, pp;
  logic        rst_b_in = 1'b0, reg_write_in = 1'b0, reg_read_in = 1'b0, clock_output_option = 1'b0, div8 = 1'b0;
  logic        pd_in = 1'b0, sb_in = 1'b0, pin_v = 1'b0, pin_oe = 1'b0;
  logic [3:0]  reg_addr_in = 4'h0, src = 4'h2;
  logic [1:0]  startup_time_select = 2'h0;
  logic [7:0]  reg_wdata_in = 8'h00, ftrim = 8'h80;
  logic [7:0]  reg_rdata_out, trim_o;
  logic        ref_on, run_o, fast_en, fast64, sat, ready, wdt, pin_o, pin_oe_o;
  logic [15:0] ticks, t0;
  int          miscompares = 0, checked = 0, n, ex;

  clock_control #(.LOCK_DELAY_CYCLES(LOCK_N), .LOOP_DELAY_A(10), .LOOP_DELAY_B(20), .EXT_DELAY_A(12),
    .EXT_DELAY_B(24), .SLEEP_LONG(50)) dut_u (
    .clock_in(clock_in), .rst_b_in(rst_b_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_write_in(reg_write_in), .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out),
    .clock_source_select_in(src), .startup_time_select_in(startup_time_select), .clock_output_option_in(clock_output_option),
    .divide_by_eight_option_in(div8), .factory_trim_in(ftrim), .power_down_sleep_in(pd_in),
    .standby_sleep_in(sb_in), .ref_osc_on_out(ref_on), .multiplier_run_out(run_o),
    .fast_clock_enable_out(fast_en), .fast_clock_64mhz_out(fast64), .loop_saturated_out(sat),
    .rc_trim_value_out(trim_o), .core_ready_out(ready), .wdt_clock_out(wdt), .clock_output_pin_out(pin_o),
    .clock_output_pin_oe_out(pin_oe_o), .port_pin_value_in(pin_v), .port_pin_oe_in(pin_oe));

  pwm_stage_model stage_u (.clock_in(clock_in), .rst_b_in(rst_b_in), .fast_enable_in(fast_en),
    .fast_64mhz_in(fast64), .fast_ticks_out(ticks));

  initial begin
    clock_in = 1'b0;
    forever #25 clock_in = ~clock_in;
  end

  task automatic give_verdict();
    if (miscompares == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clock_in);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock_in);
    reg_write_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clock_in);
    reg_write_in <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clock_in);
    reg_read_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clock_in);
    reg_read_in <= 1'b0;
    @(negedge clock_in);
    chk(reg_rdata_out, exp);
  endtask

  task automatic do_reset(input logic [3:0] s, input logic [1:0] u, input logic co, input logic [7:0] ft);
    @(posedge clock_in);
    // straps move only while reset is held
    rst_b_in <= 1'b0;
    src <= s;
    startup_time_select <= u;
    clock_output_option <= co;
    div8 <= co;
    ftrim <= ft;
    cyc(2);
    rst_b_in <= 1'b1;
  endtask

  task automatic wait_lock();
    n = 0;
    while (fast_en !== 1'b1 && n < 200) begin
      @(posedge clock_in);
      n++;
    end
    @(negedge clock_in);
  endtask

  initial begin
    for (int s = 0; s < 2; s++) begin
      for (int u = 0; u < 4; u++) begin
        do_reset(s ? SRC_EXT_CLOCK : SRC_LOOP_RC, 2'(u), 1'b0, 8'h80);
        n = 0;
        while (ready !== 1'b1 && n < 300) begin
          @(posedge clock_in);
          n++;
        end
        ex = 14 + ((u == 1) ? (s ? 12 : 10) : (u == 2) ? (s ? 24 : 20) : 0);
        chk(8'(n >= ex && n <= ex + 4), 8'h01);
      end
    end
    rd(CSR_ADDR, 8'h00);
    rd(PRESCALE_ADDR, {4'h0, PRESCALE_DIV1});
    @(posedge clock_in);
    pin_v <= 1'b1;
    pin_oe <= 1'b1;
    cyc(1);
    @(negedge clock_in);
    chk({6'h0, pin_o, pin_oe_o}, 8'h03);
    do_reset(SRC_LOOP_RC, 2'h0, 1'b0, 8'h80);
    cyc(2);
    wr(CSR_ADDR, 8'h00);
    rd(CSR_ADDR, 8'h02);
    do_reset(SRC_RC, 2'h0, 1'b1, 8'h5a);
    cyc(2);
    rd(CSR_ADDR, 8'h00);
    rd(TRIM_ADDR, 8'h5a);
    rd(PRESCALE_ADDR, {4'h0, PRESCALE_DIV8});
    wr(4'h7, 8'hff);
    rd(4'h7, 8'h00);
    chk(trim_o, 8'h5a);
    chk({7'h0, pin_oe_o}, 8'h01);
    wr(CSR_ADDR, 8'hff);
    rd(CSR_ADDR, 8'h06);
    chk({4'h0, ref_on, run_o, fast64, fast_en}, 8'h0e);
    chk(8'(ticks), 8'h00);
    wait_lock();
    chk({7'h0, fast_en}, 8'h01);
    rd(CSR_ADDR, 8'h07);
    t0 = ticks;
    cyc(4);
    @(negedge clock_in);
    chk(8'((ticks - t0) / 16'(FAST_HI_MHZ)), 8'h04);
    wr(CSR_ADDR, 8'h02);
    cyc(1);
    @(negedge clock_in);
    t0 = ticks;
    cyc(4);
    @(negedge clock_in);
    chk({7'h0, fast64}, 8'h00);
    chk(8'((ticks - t0) / 16'(FAST_LO_MHZ)), 8'h04);
    wr(TRIM_ADDR, 8'hc1);
    cyc(4);
    @(negedge clock_in);
    chk({6'h0, sat, fast_en}, 8'h02);
    chk(trim_o, 8'hc1);
    rd(CSR_ADDR, 8'h02);
    // trim back inside the locking range
    wr(TRIM_ADDR, 8'h80);
    wait_lock();
    chk({7'h0, fast_en}, 8'h01);
    wr(PRESCALE_ADDR, {4'h0, PRESCALE_MAX});
    rd(PRESCALE_ADDR, {4'h0, PRESCALE_MAX});
    wr(PRESCALE_ADDR, 8'h09);
    rd(PRESCALE_ADDR, {4'h0, PRESCALE_MAX});
    wr(PRESCALE_ADDR, 8'h01);
    n = 0;
    pp = pin_o;
    for (int k = 0; k < 16; k++) begin
      @(negedge clock_in);
      if (pin_o !== pp) n++;
      pp = pin_o;
    end
    chk(8'(n > 2), 8'h01);
    for (int k = 0; k < 2; k++) begin
      @(posedge clock_in);
      // sleep used only with the RC as system clock and the loop enabled
      pd_in <= (k == 0);
      sb_in <= (k == 1);
      cyc(6);
      @(negedge clock_in);
      chk({4'h0, ready, ref_on, run_o, fast_en}, 8'h00);
      rd(CSR_ADDR, 8'h02);
      @(posedge clock_in);
      pd_in <= 1'b0;
      sb_in <= 1'b0;
      wait_lock();
      chk({6'h0, ready, fast_en}, 8'h03);
    end
    wr(CSR_ADDR, 8'h00);
    rd(CSR_ADDR, 8'h00);
    chk({6'h0, run_o, fast_en}, 8'h00);
    give_verdict();
  end

  initial begin
    repeat (20000) @(posedge clock_in);
    miscompares++;
    give_verdict();
  end
endmodule
